// >>> src/sfe_front_end.sv
//
// Contract
// (RULE_01) Chip select high: deselected, every output line released.
// (RULE_02) Deselected: sit in low-power standby until selected again.
// (RULE_03) Chip select low selects, leaves standby, accepts instructions and data.
// (RULE_04) After power-up a high-to-low select edge must precede any instruction.
// (RULE_05) Line data is ignored while chip select is high.
// (RULE_06) Single-line input sampled on each rising serial clock edge.
// (RULE_07) Single-line read data driven on output line at falling edges.
// (RULE_08) Dual and quad: lines bidirectional, capture on rise, drive on fall.
// (RULE_09) Quad transfers use write-protect and pause pins as lines 2 and 3.
// (RULE_10) Only clock modes (0,0) and (1,1) are supported.
// (RULE_11) 35h enters four-line instruction mode, F5h exits, reset returns single.
// (RULE_12) Quad enable set: write-protect function unavailable.
// (RULE_13) Pause low while selected: tri-state output, freeze, resume on high. Code ignores pause while quad enable or four-line mode is set.
// (RULE_14) Chip select high discards a partial instruction and shift state.
// (RULE_15) Data lines released between transfers and during host-driven phases.
module sfe_front_end (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic [3:0] I_DATA_LINE_I,
  output logic [3:0] O_DATA_LINE_O,
  output logic [3:0] O_DATA_LINE_OE,
  input wire logic I_QUAD_IO_ENABLE,
  input wire logic [1:0] I_BUS_WIDTH,
  input wire logic I_TX_ACTIVE,
  input wire logic [7:0] I_TX_BYTE,
  output logic O_TX_TAKE,
  output logic [7:0] O_RX_BYTE,
  output logic O_INSTR_VALID,
  output logic O_RX_VALID,
  output logic O_STANDBY,
  output logic O_PAUSED,
  output logic O_FOUR_LINE_INSTRUCTION_MODE,
  output logic O_WRITE_PROTECT_N
);

  sfe_pkg::sfe_regs_type r_q;
  sfe_pkg::sfe_regs_type r_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_high;
  logic paused;
  logic [1:0] width;
  logic [7:0] rx_next;
  logic [7:0] tx_src;
  logic [3:0] rx_cnt_next;

  // Bits moved per serial clock edge for a width code
  function automatic logic [3:0] step(input logic [1:0] w);
    if (w == sfe_pkg::WIDTH_QUAD) begin
      step = 4'h4;
    end else if (w == sfe_pkg::WIDTH_DUAL) begin
      step = 4'h2;
    end else begin
      step = 4'h1;
    end
  endfunction : step

  // Shifts sampled line bits in, line 0 is the least significant
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic [3:0] l, input logic [1:0] w);
    if (w == sfe_pkg::WIDTH_QUAD) begin
      shift_in = {v[3:0], l};
    end else if (w == sfe_pkg::WIDTH_DUAL) begin
      shift_in = {v[5:0], l[1:0]};
    end else begin
      shift_in = {v[6:0], l[0]};
    end
  endfunction : shift_in

  // Top bits of a byte placed on the lines; single width uses line 1
  function automatic logic [3:0] out_bits(input logic [7:0] v, input logic [1:0] w);
    if (w == sfe_pkg::WIDTH_QUAD) begin
      out_bits = v[7:4];
    end else if (w == sfe_pkg::WIDTH_DUAL) begin
      out_bits = {2'h0, v[7:6]};
    end else begin
      out_bits = {2'h0, v[7], 1'b0};
    end
  endfunction : out_bits

  // Lines driven for a width code
  function automatic logic [3:0] oe_mask(input logic [1:0] w);
    if (w == sfe_pkg::WIDTH_QUAD) begin
      oe_mask = 4'hf;
    end else if (w == sfe_pkg::WIDTH_DUAL) begin
      oe_mask = 4'h3;
    end else begin
      oe_mask = 4'h2;
    end
  endfunction : oe_mask

  // Edge detection on the synchronised serial clock; select used as a synchronised level
  assign sclk_rise = r_q.sclk_sync[1] & ~r_q.sclk_sync[2]; // see (RULE_06) see (RULE_10)
  assign sclk_fall = ~r_q.sclk_sync[1] & r_q.sclk_sync[2]; // see (RULE_07) see (RULE_10)
  assign cs_high = r_q.cs_sync[1];
  // Pause pin only acts while line 3 is not a data line
  assign paused = ~cs_high & ~r_q.four_line & ~I_QUAD_IO_ENABLE & ~r_q.dl_s2[3]; // see (RULE_13)

  // Width of the current phase; quad needs quad enable or four-line mode
  always_comb begin
    if (r_q.four_line) begin
      width = sfe_pkg::WIDTH_QUAD; // see (RULE_09)
    end else if (r_q.state != sfe_pkg::ST_DATA) begin
      width = sfe_pkg::WIDTH_SINGLE;
    end else if (I_BUS_WIDTH == sfe_pkg::WIDTH_QUAD && !I_QUAD_IO_ENABLE) begin
      width = sfe_pkg::WIDTH_SINGLE;
    end else if (I_BUS_WIDTH == sfe_pkg::WIDTH_QUAD || I_BUS_WIDTH == sfe_pkg::WIDTH_DUAL) begin
      width = I_BUS_WIDTH; // see (RULE_08)
    end else begin
      width = sfe_pkg::WIDTH_SINGLE;
    end
  end

  assign rx_next = shift_in(r_q.rx_shift, r_q.dl_s2, width);
  assign rx_cnt_next = r_q.rx_cnt + step(width);
  assign tx_src = (r_q.tx_cnt == 4'h0) ? I_TX_BYTE : r_q.tx_shift;

  // Next state of the whole front end
  always_comb begin
    r_d = r_q;
    r_d.instr_valid = 1'b0;
    r_d.rx_valid = 1'b0;
    r_d.tx_take = 1'b0;
    r_d.sclk_sync = {r_q.sclk_sync[1:0], I_SCLK};
    r_d.cs_sync = {r_q.cs_sync[0], I_CS_N};
    r_d.dl_s1 = I_DATA_LINE_I;
    r_d.dl_s2 = r_q.dl_s1;
    if (cs_high) begin
      // Deselect: standby, drop partial bytes, release lines
      r_d.state = sfe_pkg::ST_STANDBY; // see (RULE_01) see (RULE_02) see (RULE_05)
      r_d.armed = 1'b1; // see (RULE_04)
      r_d.rx_shift = 8'h00; // see (RULE_14)
      r_d.rx_cnt = 4'h0;
      r_d.tx_cnt = 4'h0;
      r_d.dl_oe = 4'h0; // see (RULE_15)
    end else begin
      case (r_q.state)
        sfe_pkg::ST_STANDBY: begin
          if (r_q.armed) begin
            r_d.state = sfe_pkg::ST_INSTR; // see (RULE_03) see (RULE_04)
          end
        end
        sfe_pkg::ST_INSTR, sfe_pkg::ST_DATA: begin
          if (paused) begin
            r_d.dl_oe = 4'h0; // see (RULE_13)
          end else if (r_q.state == sfe_pkg::ST_DATA && I_TX_ACTIVE) begin
            // Read phase: drive on falling edges
            if (sclk_fall) begin
              r_d.tx_take = (r_q.tx_cnt == 4'h0);
              r_d.dl_o = out_bits(tx_src, width); // see (RULE_07) see (RULE_08)
              r_d.dl_oe = oe_mask(width); // see (RULE_09)
              r_d.tx_shift = tx_src << step(width);
              r_d.tx_cnt = (r_q.tx_cnt + step(width) == sfe_pkg::BYTE_BITS) ? 4'h0 : r_q.tx_cnt + step(width);
            end
          end else begin
            // Host-driven phase: lines released, capture on rising edges
            r_d.dl_oe = 4'h0; // see (RULE_15)
            r_d.tx_cnt = 4'h0;
            if (sclk_rise) begin
              r_d.rx_shift = rx_next; // see (RULE_06) see (RULE_08)
              r_d.rx_cnt = rx_cnt_next;
              if (rx_cnt_next == sfe_pkg::BYTE_BITS) begin
                r_d.rx_cnt = 4'h0;
                r_d.rx_byte = rx_next;
                if (r_q.state == sfe_pkg::ST_INSTR) begin
                  r_d.instr_valid = 1'b1; // see (RULE_03)
                  r_d.state = sfe_pkg::ST_DATA;
                  if (rx_next == sfe_pkg::CMD_ENTER_FOUR) begin
                    r_d.four_line = 1'b1; // see (RULE_11)
                  end else if (rx_next == sfe_pkg::CMD_EXIT_FOUR) begin
                    r_d.four_line = 1'b0; // see (RULE_11)
                  end
                end else begin
                  r_d.rx_valid = 1'b1;
                end
              end
            end
          end
        end
        default: begin
          r_d.state = sfe_pkg::ST_STANDBY;
        end
      endcase
    end
  end

  // State register; reset returns single-line mode
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      r_q <= sfe_pkg::REGS_RESET; // see (RULE_11)
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs
  assign O_DATA_LINE_O = r_q.dl_o;
  assign O_DATA_LINE_OE = r_q.dl_oe;
  assign O_TX_TAKE = r_q.tx_take;
  assign O_RX_BYTE = r_q.rx_byte;
  assign O_INSTR_VALID = r_q.instr_valid;
  assign O_RX_VALID = r_q.rx_valid;
  assign O_STANDBY = (r_q.state == sfe_pkg::ST_STANDBY);
  assign O_PAUSED = paused;
  assign O_FOUR_LINE_INSTRUCTION_MODE = r_q.four_line;
  // Write-protect level only when line 2 is not a data line
  assign O_WRITE_PROTECT_N = (I_QUAD_IO_ENABLE | r_q.four_line) ? 1'b1 : r_q.dl_s2[2]; // see (RULE_12)

  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RSTN);

  desel_release_a: assert property (cs_high |=> r_q.dl_oe == 4'h0) // see (RULE_01)
    else $error("Lines driven while deselected");
  desel_standby_a: assert property (cs_high |=> O_STANDBY) // see (RULE_02)
    else $error("Not in standby while deselected");
  select_wake_a: assert property (r_q.armed && !cs_high && O_STANDBY |=> r_q.state == sfe_pkg::ST_INSTR) // see (RULE_03)
    else $error("Select did not leave standby");
  arm_first_a: assert property (!r_q.armed |=> O_STANDBY && !O_INSTR_VALID) // see (RULE_04)
    else $error("Instruction taken before first select edge");
  desel_ignore_a: assert property (cs_high |=> !O_INSTR_VALID && !O_RX_VALID && r_q.rx_cnt == 4'h0) // see (RULE_05)
    else $error("Data accepted while deselected");
  rise_sample_a: assert property (!sclk_rise && !cs_high |=> $stable(r_q.rx_shift)) // see (RULE_06)
    else $error("Input shifted without rising edge");
  fall_drive_a: assert property (!sclk_fall |=> $stable(r_q.dl_o)) // see (RULE_07)
    else $error("Output changed without falling edge");
  pause_release_a: assert property (paused |=> r_q.dl_oe == 4'h0) // see (RULE_13)
    else $error("Output driven during pause");
  partial_drop_a: assert property ($rose(cs_high) |=> r_q.rx_shift == 8'h00 && r_q.rx_cnt == 4'h0) // see (RULE_14)
    else $error("Partial instruction kept after deselect");
  enter_four_a: assert property (O_INSTR_VALID && O_RX_BYTE == sfe_pkg::CMD_ENTER_FOUR |-> r_q.four_line) // see (RULE_11)
    else $error("Four-line mode not entered");
  wp_masked_a: assert property (I_QUAD_IO_ENABLE |-> O_WRITE_PROTECT_N) // see (RULE_12)
    else $error("Write protect active with quad enable");

endmodule : sfe_front_end

// >>> src/sfe_pkg.sv
package sfe_pkg;
  // Instruction codes that switch the instruction width
  localparam logic [7:0] CMD_ENTER_FOUR = 8'h35;
  localparam logic [7:0] CMD_EXIT_FOUR = 8'hf5;
  // Bits in one transferred byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Line width codes of a transfer phase
  localparam logic [1:0] WIDTH_SINGLE = 2'h0;
  localparam logic [1:0] WIDTH_DUAL = 2'h1;
  localparam logic [1:0] WIDTH_QUAD = 2'h2;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA = 2'b10
  } sfe_state_type;

  typedef struct packed {
    sfe_state_type state;
    logic [2:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [3:0] dl_s1;
    logic [3:0] dl_s2;
    logic armed;
    logic four_line;
    logic [7:0] rx_shift;
    logic [3:0] rx_cnt;
    logic [7:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [3:0] dl_o;
    logic [3:0] dl_oe;
    logic [7:0] rx_byte;
    logic instr_valid;
    logic rx_valid;
    logic tx_take;
  } sfe_regs_type;

  // Values after reset: standby, single-line mode, all lines released
  // Select sync starts low so a select held through reset is not taken as a fresh edge
  localparam sfe_regs_type REGS_RESET = '{
    state: ST_STANDBY, sclk_sync: 3'h0, cs_sync: 2'h0, dl_s1: 4'hf, dl_s2: 4'hf,
    armed: 1'b0, four_line: 1'b0, rx_shift: 8'h00, rx_cnt: 4'h0, tx_shift: 8'h00,
    tx_cnt: 4'h0, dl_o: 4'h0, dl_oe: 4'h0, rx_byte: 8'h00, instr_valid: 1'b0,
    rx_valid: 1'b0, tx_take: 1'b0};
endpackage : sfe_pkg

// >>> testbench/sfe_host.sv
module sfe_host (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] ho,
  output logic [3:0] hoe,
  input wire logic [3:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cpol;
  // Clock stands at its idle level between frames
  initial begin
    sclk = 1'b0;
    cpol = 1'b0;
    cs_n = 1'b1;
    ho = 4'h0;
    hoe = 4'h0;
  end
  // Select or deselect, then settle
  task sel(input logic s);
    cs_n = !s;
    #80;
  endtask : sel
  // Idle level: low for mode (0,0), high for mode (1,1); change only while deselected
  task mode(input logic hi);
    cpol = hi;
    sclk = hi;
    #80;
  endtask : mode
  // Groups msb first, changed while clock low
  task send(input logic [7:0] b, input int w);
    for (int i = 8; i > 0; i -= w) begin
      if (cpol) sclk = 1'b0;
      ho = 4'(b >> (i - w));
      hoe = 4'((1 << w) - 1);
      #40 sclk = 1'b1;
      #40 if (!cpol) sclk = 1'b0;
    end
    hoe = 4'h0;
  endtask : send
  // Late sample in high phase covers the front end's sync delay
  task recv(input int w, output logic [7:0] b);
    for (int i = 0; i < 8; i += w) begin
      if (cpol) sclk = 1'b0;
      #40 sclk = 1'b1;
      #30 b = (b << w) | 8'(w == 1 ? 4'(line[1]) : line & 4'((1 << w) - 1));
      #10 if (!cpol) sclk = 1'b0;
    end
  endtask : recv
endmodule : sfe_host

// >>> testbench/test_sfe_front_end.sv
module test_sfe_front_end;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, quad_en, tx_act, rd_req, sclk, cs_n, take, rxv, iv, sb, pz, four, wp_n;
  logic [1:0] bus_w;
  logic [7:0] tx_byte, got_instr, got_rx, rd, rx_byte;
  logic [3:0] d_o, d_oe, h_o, h_oe, pin_lo, ln;
  int failures, tests_run, n_instr, idle_cnt, n_take;
  // Pull-ups on every line; a pin may be held low from outside
  assign ln = (d_oe & d_o | ~d_oe & h_oe & h_o | ~d_oe & ~h_oe) & ~pin_lo;
  sfe_front_end u_sfe_front_end (.I_MCLK(mclk), .I_RSTN(rstn), .I_SCLK(sclk), .I_CS_N(cs_n),
    .I_DATA_LINE_I(ln), .O_DATA_LINE_O(d_o), .O_DATA_LINE_OE(d_oe), .I_QUAD_IO_ENABLE(quad_en),
    .I_BUS_WIDTH(bus_w), .I_TX_ACTIVE(tx_act), .I_TX_BYTE(tx_byte), .O_TX_TAKE(take),
    .O_RX_BYTE(rx_byte), .O_INSTR_VALID(iv), .O_RX_VALID(rxv), .O_STANDBY(sb), .O_PAUSED(pz),
    .O_FOUR_LINE_INSTRUCTION_MODE(four), .O_WRITE_PROTECT_N(wp_n));
  sfe_host host (.sclk(sclk), .cs_n(cs_n), .ho(h_o), .hoe(h_oe), .line(ln));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic oops(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : oops
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp) oops(m);
  endtask : chk
  task automatic wrap_up;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // Core stand-in: catch bytes, start reads, watch released lines
  always @(posedge mclk) begin
    if (iv) begin
      got_instr <= rx_byte;
      n_instr <= n_instr + 1;
      tx_act <= rd_req;
    end
    if (rxv) got_rx <= rx_byte;
    if (take) n_take <= n_take + 1;
    if (cs_n) tx_act <= 1'b0;
    idle_cnt <= (cs_n || !tx_act) ? idle_cnt + 1 : 0;
    if (idle_cnt > 3 && d_oe !== 4'h0) oops("lines driven while released");
  end
  task automatic t_idle;
    chk(8'(sb), 8'h1, "standby after reset");
    chk(8'(four), 8'h0, "four-line after reset");
    host.send(8'hff, 1);
    tick(5);
    chk(8'(n_instr), 8'h0, "bits taken while deselected");
  endtask : t_idle
  task automatic t_write;
    host.sel(1'b1);
    chk(8'(sb), 8'h0, "still standby");
    host.send(8'ha5, 1);
    host.send(8'h3c, 1);
    tick(8);
    chk(got_instr, 8'ha5, "instruction byte");
    chk(got_rx, 8'h3c, "data byte");
    host.sel(1'b0);
    chk(8'(sb), 8'h1, "no standby after deselect");
  endtask : t_write
  // Four bits on line0, deselect, then a whole byte
  task automatic t_partial;
    host.sel(1'b1);
    host.send(8'hff, 2);
    host.sel(1'b0);
    host.sel(1'b1);
    host.send(8'h96, 1);
    tick(8);
    chk(got_instr, 8'h96, "partial byte kept");
    host.sel(1'b0);
  endtask : t_partial
  // Clocks during pause must not shift
  task automatic t_pause;
    host.sel(1'b1);
    host.send(8'hff, 2);
    pin_lo = 4'h8;
    tick(4);
    chk(8'(pz), 8'h1, "pause not seen");
    host.send(8'h00, 2);
    pin_lo = 4'h0;
    tick(4);
    host.send(8'h00, 2);
    tick(8);
    chk(got_instr, 8'hf0, "pause lost or shifted");
    host.sel(1'b0);
  endtask : t_pause
  task automatic t_wp_four;
    pin_lo = 4'h4;
    tick(4);
    chk(8'(wp_n), 8'h0, "write-protect pin lost");
    quad_en = 1'b1;
    tick(4);
    chk(8'(wp_n), 8'h1, "protect with quad enable");
    quad_en = 1'b0;
    pin_lo = 4'h0;
    host.sel(1'b1);
    host.send(sfe_pkg::CMD_ENTER_FOUR, 1);
    host.sel(1'b0);
    chk(8'(four), 8'h1, "enter four-line");
    host.sel(1'b1);
    host.send(sfe_pkg::CMD_EXIT_FOUR, 4);
    tick(8);
    chk(got_instr, sfe_pkg::CMD_EXIT_FOUR, "nibble instruction");
    host.sel(1'b0);
    chk(8'(four), 8'h0, "exit four-line");
  endtask : t_wp_four
  // Reset while selected: single-line again, nothing taken before a fresh select edge
  task automatic t_reset;
    int k;
    host.sel(1'b1);
    host.send(sfe_pkg::CMD_ENTER_FOUR, 1);
    tick(8);
    chk(8'(four), 8'h1, "enter four-line before reset");
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    chk(8'(four), 8'h0, "four-line kept over reset");
    k = n_instr;
    host.send(8'h5a, 1);
    tick(8);
    chk(8'(n_instr - k), 8'h0, "instruction without fresh select");
    chk(8'(sb), 8'h1, "left standby without select edge");
    host.sel(1'b0);
    host.sel(1'b1);
    host.send(8'h5a, 1);
    tick(8);
    chk(got_instr, 8'h5a, "instruction after fresh select");
    host.sel(1'b0);
  endtask : t_reset
  task automatic t_read(input logic [1:0] code, input int w, input logic hi);
    int k;
    host.mode(hi);
    quad_en = 1'b1;
    bus_w = code;
    tx_byte = 8'hc3 ^ 8'(w);
    rd_req = 1'b1;
    k = n_take;
    host.sel(1'b1);
    host.send(8'h6b, 1);
    host.recv(w, rd);
    chk(rd, 8'hc3 ^ 8'(w), "read byte");
    chk(8'(d_oe), 8'(w == 1 ? 4'h2 : 4'((1 << w) - 1)), "read enables");
    tick(5);
    // One byte load per byte boundary; mode (0,0) adds the fall that ends the instruction
    chk(8'(n_take - k), hi ? 8'h1 : 8'h2, "byte loads");
    host.sel(1'b0);
    rd_req = 1'b0;
  endtask : t_read
  initial begin
    rstn = 1'b0;
    quad_en = 1'b0;
    bus_w = 2'h0;
    tx_byte = 8'h00;
    rd_req = 1'b0;
    pin_lo = 4'h0;
    tick(12);
    rstn = 1'b1;
    tick(4);
    t_idle();
    t_write();
    t_partial();
    t_pause();
    t_wp_four();
    t_reset();
    t_read(sfe_pkg::WIDTH_SINGLE, 1, 1'b0);
    t_read(sfe_pkg::WIDTH_DUAL, 2, 1'b0);
    t_read(sfe_pkg::WIDTH_QUAD, 4, 1'b0);
    t_read(sfe_pkg::WIDTH_SINGLE, 1, 1'b1);
    wrap_up();
  end
  // Run takes about 14 us
  initial begin
    #200000;
    oops("watchdog expired");
    wrap_up();
  end
endmodule : test_sfe_front_end
